// ---- shared/ccp_pkg.sv ----
package ccp_pkg;
    // register indices on the plain register port
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_CAP_SRC = 2'h1;
    localparam logic [1:0] ADDR_VAL_LO = 2'h2;
    localparam logic [1:0] ADDR_VAL_HI = 2'h3;
    // control field positions
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_OUT_BIT = 5;
    localparam int CTL_ALIGN_BIT = 4;
    // reset values, prescale match counts and pulse length
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [2:0] RST_CAP_SRC = 3'h0;
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [3:0] PRESCALE_16 = 4'hf;
    localparam logic [3:0] PRESCALE_4 = 4'h3;
    localparam logic [1:0] PULSE_CYCLES = 2'h1;

    // operating_mode_field encodings
    typedef enum logic [3:0] {
        CCP_OFF = 4'b0000,
        CCP_CMP_TGL_CLR = 4'b0001,
        CCP_CMP_TGL = 4'b0010,
        CCP_CAP_BOTH = 4'b0011,
        CCP_CAP_FALL = 4'b0100,
        CCP_CAP_RISE = 4'b0101,
        CCP_CAP_RISE4 = 4'b0110,
        CCP_CAP_RISE16 = 4'b0111,
        CCP_CMP_SET = 4'b1000,
        CCP_CMP_CLR = 4'b1001,
        CCP_CMP_PULSE = 4'b1010,
        CCP_CMP_PULSE_CLR = 4'b1011,
        CCP_RSV_C = 4'b1100,
        CCP_RSV_D = 4'b1101,
        CCP_RSV_E = 4'b1110,
        CCP_PWM = 4'b1111
    } ccp_mode_t;

    // signals from the timers
    typedef struct packed {
        logic [15:0] sixteen_bit_timer;
        logic [7:0] period_timer;
        logic [7:0] period_limit;
        logic [1:0] base_low_bits;
        logic period_increment;
    } ccp_timer_t;

    // candidate capture sources
    typedef struct packed {
        logic mapped_input_pin;
        logic comparator_one_out;
        logic comparator_two_out;
        logic numeric_oscillator_output;
        logic pin_change_event;
        logic logic_cell_one_out;
        logic logic_cell_two_out;
    } ccp_sources_t;
endpackage

// ---- rtl/ccp_unit.sv ----
`timescale 1ns/100ps
// Summary of operation
// - enable bit 7 low disables unit; high runs selected mode
// - control bit 5 reads output level; writes ignored
// - alignment bit 4 picks right(0)/left(1) PWM width; ignored otherwise
// - mode 1111 is PWM; 1100 to 1110 reserved, no events and output level held, not cleared as in off
// - mode 1011 pulses output on match and clears 16-bit timer
// - mode 1010 pulses output on match without timer clear
// - mode 1001 drives output low, 1000 drives high on match
// - mode 0111 captures every 16th rising edge, 0110 every 4th
// - capture on rising 0101, falling 0100, both edges 0011
// - 0010 toggles output on match; 0001 toggles and clears timer
// - mode 0000 turns everything off and resets internal state
// - every mode event raises event flag and trigger if selected
// - 3-bit source select picks capture input; 111 reserved, reads low
// - capture copies timer low and high bytes into value bytes
// - compare match requires both value bytes equal timer bytes
// - right-aligned width: low byte bits 7:0, high byte bits 1:0
// - left-aligned width: high byte bits 9:2, low byte bits 7:6
// - control bit 6 and source bits 7:3 read zero
// - period rollover clears timer, sets output unless zero, latches duty
// - PWM output goes low when time base equals buffered width
// - time base is period timer plus two low-order bits
module ccp_unit
(
    input wire logic i_clk, // 25 MHz system clock
    input wire logic i_rst_n, // synchronous reset, active low
    input wire logic [1:0] i_addr, // register index
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [7:0] o_rdata, // read data, cycle after strobe
    input wire ccp_pkg::ccp_timer_t i_timer, // timer values
    input wire ccp_pkg::ccp_sources_t i_src, // capture sources
    input wire logic i_adc_sel, // unit chosen as conversion trigger
    output logic o_out, // output pin level
    output logic o_event, // unit_event_flag set pulse
    output logic o_adc_trigger, // conversion trigger pulse
    output logic o_timer_clear, // clear request to 16-bit timer
    output logic o_period_clear // clear request to period timer
);
    import ccp_pkg::*;

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    logic unit_enable;
    logic width_alignment;
    ccp_mode_t operating_mode_field;
    logic [2:0] capture_source_field;
    logic [7:0] value_low_byte;
    logic [7:0] value_high_byte;
    logic out_level;
    logic [9:0] duty_buffer;
    logic [1:0] sync_ff;
    logic sync_prev;
    logic [3:0] edge_count;
    logic [1:0] pulse_cnt;
    logic match_prev;

    logic active;
    logic is_capture;
    logic is_compare;
    logic is_pwm;
    logic src_sel;
    logic rise;
    logic fall;
    logic cap_edge;
    logic cap_event;
    logic match;
    logic match_event;
    logic pwm_roll;
    logic [9:0] width_value;
    logic [9:0] time_base;
    logic wr_lo;
    logic wr_hi;

    //------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------
    // reserved and off codes fall into none of the groups
    assign active = unit_enable && (operating_mode_field != CCP_OFF);
    assign is_pwm = active && (operating_mode_field == CCP_PWM);
    assign is_capture = active && (operating_mode_field inside
        {CCP_CAP_BOTH, CCP_CAP_FALL, CCP_CAP_RISE, CCP_CAP_RISE4, CCP_CAP_RISE16});
    assign is_compare = active && (operating_mode_field inside
        {CCP_CMP_TGL_CLR, CCP_CMP_TGL, CCP_CMP_SET, CCP_CMP_CLR,
         CCP_CMP_PULSE, CCP_CMP_PULSE_CLR});
    assign wr_lo = i_wr && (i_addr == ADDR_VAL_LO);
    assign wr_hi = i_wr && (i_addr == ADDR_VAL_HI);

    //------------------------------------------------------------
    // register writes
    //------------------------------------------------------------
    // control register; output level bit not writable
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            unit_enable <= RST_CONTROL[CTL_ENABLE_BIT];
            width_alignment <= RST_CONTROL[CTL_ALIGN_BIT];
            operating_mode_field <= CCP_OFF;
        end
        else if (i_wr && (i_addr == ADDR_CONTROL))
        begin
            unit_enable <= i_wdata[CTL_ENABLE_BIT];
            width_alignment <= i_wdata[CTL_ALIGN_BIT];
            operating_mode_field <= ccp_mode_t'(i_wdata[3:0]);
        end
    end

    // capture source select
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            capture_source_field <= RST_CAP_SRC;
        else if (i_wr && (i_addr == ADDR_CAP_SRC))
            capture_source_field <= i_wdata[2:0];
    end

    // value bytes: software write, or capture load; capture wins
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            value_low_byte <= RST_VALUE;
            value_high_byte <= RST_VALUE;
        end
        else if (cap_event)
        begin
            value_low_byte <= i_timer.sixteen_bit_timer[7:0];
            value_high_byte <= i_timer.sixteen_bit_timer[15:8];
        end
        else
        begin
            if (wr_lo)
                value_low_byte <= i_wdata;
            if (wr_hi)
                value_high_byte <= i_wdata;
        end
    end

    //------------------------------------------------------------
    // register reads
    //------------------------------------------------------------
    // read data valid the cycle after the strobe; unused bits zero
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            if (i_addr == ADDR_CONTROL)
                o_rdata <= {unit_enable, 1'b0, out_level, width_alignment,
                    operating_mode_field};
            else if (i_addr == ADDR_CAP_SRC)
                o_rdata <= {5'h00, capture_source_field};
            else if (i_addr == ADDR_VAL_LO)
                o_rdata <= value_low_byte;
            else
                o_rdata <= value_high_byte;
        end
        else
            o_rdata <= 8'h00;
    end

    //------------------------------------------------------------
    // capture path
    //------------------------------------------------------------
    // source multiplexer
    always_comb
    begin
        case (capture_source_field)
            3'h0: src_sel = i_src.mapped_input_pin;
            3'h1: src_sel = i_src.comparator_one_out;
            3'h2: src_sel = i_src.comparator_two_out;
            3'h3: src_sel = i_src.numeric_oscillator_output;
            3'h4: src_sel = i_src.pin_change_event;
            3'h5: src_sel = i_src.logic_cell_one_out;
            3'h6: src_sel = i_src.logic_cell_two_out;
            default: src_sel = 1'b0;
        endcase
    end

    // two-stage synchroniser then edge history
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            sync_ff <= 2'h0;
            sync_prev <= 1'b0;
        end
        else
        begin
            sync_ff <= {sync_ff[0], src_sel};
            sync_prev <= sync_ff[1];
        end
    end

    assign rise = sync_ff[1] && !sync_prev;
    assign fall = !sync_ff[1] && sync_prev;

    // qualifying edge per capture mode
    always_comb
    begin
        case (operating_mode_field)
            CCP_CAP_BOTH: cap_edge = rise || fall;
            CCP_CAP_FALL: cap_edge = fall;
            default: cap_edge = rise;
        endcase
    end

    // prescale counter for every 4th or 16th rising edge
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !is_capture)
            edge_count <= 4'h0;
        else if (cap_edge && (operating_mode_field inside {CCP_CAP_RISE4, CCP_CAP_RISE16}))
            edge_count <= (cap_event) ? 4'h0 : edge_count + 4'h1;
    end

    always_comb
    begin
        cap_event = 1'b0;
        if (is_capture && cap_edge)
        begin
            if (operating_mode_field == CCP_CAP_RISE16)
                cap_event = (edge_count == PRESCALE_16);
            else if (operating_mode_field == CCP_CAP_RISE4)
                cap_event = (edge_count == PRESCALE_4);
            else
                cap_event = 1'b1;
        end
    end

    //------------------------------------------------------------
    // compare path
    //------------------------------------------------------------
    // match on both bytes; one event per match entry
    assign match = (value_high_byte == i_timer.sixteen_bit_timer[15:8])
        && (value_low_byte == i_timer.sixteen_bit_timer[7:0]);
    assign match_event = is_compare && match && !match_prev;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            match_prev <= 1'b0;
        else
            match_prev <= is_compare && match;
    end

    // timer clear request on match for clearing modes
    assign o_timer_clear = match_event && (operating_mode_field inside
        {CCP_CMP_PULSE_CLR, CCP_CMP_TGL_CLR});

    //------------------------------------------------------------
    // pwm path
    //------------------------------------------------------------
    // width assembly by alignment
    assign width_value = width_alignment
        ? {value_high_byte, value_low_byte[7:6]}
        : {value_high_byte[1:0], value_low_byte};
    assign time_base = {i_timer.period_timer, i_timer.base_low_bits};
    assign pwm_roll = is_pwm && i_timer.period_increment
        && (i_timer.period_timer == i_timer.period_limit);
    assign o_period_clear = pwm_roll;

    // duty double buffer
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !active)
            duty_buffer <= 10'h000;
        else if (pwm_roll)
            duty_buffer <= width_value;
    end

    //------------------------------------------------------------
    // output level
    //------------------------------------------------------------
    // pulse counter keeps the pulse high for a fixed count
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !active)
            pulse_cnt <= 2'h0;
        else if (match_event && (operating_mode_field inside
            {CCP_CMP_PULSE, CCP_CMP_PULSE_CLR}))
            pulse_cnt <= PULSE_CYCLES;
        else if (pulse_cnt != 2'h0)
            pulse_cnt <= pulse_cnt - 2'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || !active)
            out_level <= 1'b0;
        else if (is_pwm)
        begin
            if (pwm_roll)
                out_level <= (width_value != 10'h000);
            // looks one step ahead: the pin is a flop and must be low while the
            // time base equals the width; assumes the time base steps each clock
            else if ((time_base + 10'h001) == duty_buffer)
                out_level <= 1'b0;
        end
        else if (match_event)
        begin
            case (operating_mode_field)
                CCP_CMP_SET: out_level <= 1'b1;
                CCP_CMP_CLR: out_level <= 1'b0;
                CCP_CMP_TGL, CCP_CMP_TGL_CLR: out_level <= !out_level;
                default: out_level <= 1'b1;
            endcase
        end
        else if (pulse_cnt == 2'h1)
            out_level <= 1'b0;
    end

    assign o_out = out_level;

    //------------------------------------------------------------
    // event flag and trigger
    //------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_event <= 1'b0;
            o_adc_trigger <= 1'b0;
        end
        else
        begin
            o_event <= cap_event || match_event || pwm_roll;
            o_adc_trigger <= i_adc_sel && (cap_event || match_event || pwm_roll);
        end
    end
endmodule

// ---- testbench/ccp_unit_chk.sv ----
`timescale 1ns/100ps
// ------------------------------
// port checker for the unit
// ------------------------------
module ccp_unit_chk
(
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // reset, active low
    input wire logic [1:0] i_addr, // register index
    input wire logic [7:0] i_wdata, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    input wire logic [7:0] o_rdata, // read data
    input wire ccp_pkg::ccp_timer_t i_timer, // timers
    input wire ccp_pkg::ccp_sources_t i_src, // sources
    input wire logic i_adc_sel, // trigger select
    input wire logic o_out, // output level
    input wire logic o_event, // event pulse
    input wire logic o_adc_trigger, // trigger pulse
    input wire logic o_timer_clear, // timer clear
    input wire logic o_period_clear // period clear
);
    import ccp_pkg::*;
    logic [7:0] ctl;
    logic [2:0] sel;
    logic [15:0] val;
    logic live;
    // shadow copies of the written registers
    always_ff @(posedge i_clk)
        if (!i_rst_n)
        begin
            ctl <= 8'h00;
            sel <= 3'h0;
            val <= 16'h0000;
        end
        else if (i_wr)
        begin
            if (i_addr == ADDR_CONTROL)
                ctl <= i_wdata;
            if (i_addr == ADDR_CAP_SRC)
                sel <= i_wdata[2:0];
            if (i_addr == ADDR_VAL_LO)
                val[7:0] <= i_wdata;
            if (i_addr == ADDR_VAL_HI)
                val[15:8] <= i_wdata;
        end
    // enabled and in a working mode
    assign live = ctl[7] && !(ctl[3:0] inside {4'h0, 4'hc, 4'hd, 4'he});
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_pulse;
        o_out ##1 !o_out;
    endsequence
    sequence s_cap_seen;
        ##[3:4] o_event;
    endsequence
    a_out_view: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_CONTROL
        |-> !o_rdata[6] && o_rdata[5] == $past(o_out)) else $error("control readback wrong");
    a_src_zero: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_CAP_SRC |-> o_rdata[7:3] == 5'h00)
        else $error("source upper bits not zero");
    a_idle_quiet: assert property (
        !live && !$past(live) |-> !o_out && !o_event) else $error("idle unit active");
    a_clr_cause: assert property (
        o_timer_clear |-> live && ctl[3:0] inside {4'hb, 4'h1}
        && i_timer.sixteen_bit_timer == val) else $error("timer clear without match");
    a_pulse_shape: assert property (
        live && ctl[3:0] inside {4'ha, 4'hb} && $rose(o_out) |-> s_pulse)
        else $error("pulse not one cycle");
    a_cap_delay: assert property (
        live && ctl[3:0] == 4'h5 && sel == 3'h0 && $rose(i_src.mapped_input_pin)
        |-> s_cap_seen) else $error("capture event missing");
    a_trig_gate: assert property (
        o_adc_trigger |-> o_event && $past(i_adc_sel)) else $error("trigger without event");
    a_roll_cause: assert property (
        o_period_clear |-> live && ctl[3:0] == 4'hf && i_timer.period_increment
        && i_timer.period_timer == i_timer.period_limit) else $error("bad period clear");
endmodule

// ---- testbench/ccp_tmr_model.sv ----
`timescale 1ns/100ps
// ------------------------------
// timer side model
// ------------------------------
module ccp_tmr_model
(
    input wire logic i_clk, // clock
    input wire logic i_rst_n, // reset, active low
    input wire logic i_run, // 16-bit timer counts
    input wire logic i_zero, // bench clears 16-bit timer
    input wire logic i_clr, // unit clears 16-bit timer
    input wire logic i_pclr, // unit period clear
    input wire logic [7:0] i_limit, // period limit
    output ccp_pkg::ccp_timer_t o_timer // timer values
);
    import ccp_pkg::*;
    logic [15:0] t16;
    logic [7:0] t8;
    logic [1:0] div;
    // low time base bits come from the clock divider at 1:1 prescale
    assign o_timer = {t16, t8, i_limit, div, div == 2'h3};
    // 16-bit timer, a clear beats counting
    always_ff @(posedge i_clk)
        if (!i_rst_n || i_zero || i_clr)
            t16 <= 16'h0000;
        else if (i_run)
            t16 <= t16 + 16'h0001;
    // divider and period timer, wraps after the limit
    always_ff @(posedge i_clk)
    begin
        div <= i_rst_n ? div + 2'h1 : 2'h0;
        if (!i_rst_n)
            t8 <= 8'h00;
        else if (div == 2'h3)
            t8 <= (i_pclr || t8 == i_limit) ? 8'h00 : t8 + 8'h01;
    end
endmodule

// ---- testbench/ccp_unit_tb.sv ----
`timescale 1ns/100ps
module ccp_unit_tb;
    import ccp_pkg::*;
    // ------------------------------
    // stimulus tables and signals
    // ------------------------------
    localparam logic [17:0] REG_ROWS [5] = '{{ADDR_CONTROL, 8'h7c, 8'h1c},
        {ADDR_CAP_SRC, 8'hff, 8'h07}, {ADDR_VAL_LO, 8'ha5, 8'ha5},
        {ADDR_VAL_HI, 8'h5a, 8'h5a}, {ADDR_CAP_SRC, 8'hf8, 8'h00}};
    // control, then expected output, timer cleared, event seen
    localparam logic [10:0] CMP_ROWS [8] = '{{8'h98, 3'h5}, {8'h89, 3'h1}, {8'h82, 3'h5},
        {8'h81, 3'h7}, {8'h8a, 3'h1}, {8'h8b, 3'h3}, {8'h08, 3'h0}, {8'h8c, 3'h0}};
    localparam logic [13:0] CAP_ROWS [5] = '{{8'h85, 6'h10}, {8'h84, 6'h10},
        {8'h83, 6'h20}, {8'h86, 6'h04}, {8'h87, 6'h01}};
    // control, low byte, high byte, high cycles per 16-step period
    localparam logic [27:0] PWM_ROWS [4] = '{{8'h8f, 8'h05, 8'hfc, 4'h5},
        {8'h9f, 8'h7f, 8'h02, 4'h9}, {8'h8f, 8'h00, 8'h00, 4'h0}, {8'h9f, 8'hc0, 8'h03, 4'hf}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic adc_sel = 1'b0;
    logic run = 1'b0;
    logic zero = 1'b0;
    ccp_sources_t src = '0;
    ccp_timer_t tmr;
    logic [7:0] rdata;
    logic out, evt, trig, tclr, pclr;
    int err_total = 0;
    int checked = 0;
    int evts = 0;
    ccp_unit i_ccp_unit (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_timer(tmr), .i_src(src),
        .i_adc_sel(adc_sel), .o_out(out), .o_event(evt), .o_adc_trigger(trig),
        .o_timer_clear(tclr), .o_period_clear(pclr));
    ccp_tmr_model i_ccp_tmr_model (.i_clk(clk), .i_rst_n(rst_n), .i_run(run),
        .i_zero(zero), .i_clr(tclr), .i_pclr(pclr), .i_limit(8'h03), .o_timer(tmr));
    // ------------------------------
    // clock, event count, tasks
    // ------------------------------
    initial
        forever #20 clk = ~clk;
    always @(posedge clk)
        if (evt === 1'b1)
            evts++;
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        {addr, rd} <= {a, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one source pulse, four cycles high then four low
    task automatic pulse(input logic [6:0] v);
        @(posedge clk);
        src <= v;
        repeat (4) @(posedge clk);
        src <= '0;
        repeat (4) @(posedge clk);
    endtask
    task automatic wait_hit(input bit roll, output bit got, output bit trg);
        got = 1'b0;
        for (int n = 0; n < 40 && !got; n++)
        begin
            @(negedge clk);
            got = ((roll ? pclr : evt) === 1'b1);
            trg = (trig === 1'b1);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // whole run needs about 1500 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end
    initial
    begin
        int n, n0;
        logic [7:0] d, h;
        logic [15:0] t;
        bit got, gtr;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            rd_reg(k[1:0], d);
            chk(d, (k < 4) ? 8'h00 : REG_ROWS[0][7:0], "value before write");
            wr_reg(REG_ROWS[k][17:16], REG_ROWS[k][15:8]);
            rd_reg(REG_ROWS[k][17:16], d);
            chk(d, REG_ROWS[k][7:0], "readback");
        end
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(ADDR_CONTROL, 8'h00);
            {zero, run, adc_sel} <= {2'b10, k[0]};
            wr_reg(ADDR_VAL_LO, 8'h10);
            zero <= 1'b0;
            wr_reg(ADDR_VAL_HI, 8'h00);
            wr_reg(ADDR_CONTROL, CMP_ROWS[k][10:3]);
            run <= 1'b1;
            wait_hit(1'b0, got, gtr);
            chk(got, CMP_ROWS[k][0], "match event");
            chk(gtr, got & k[0], "conversion trigger");
            repeat (2) @(posedge clk);
            #1 chk(out, CMP_ROWS[k][2], "output");
            chk(tmr.sixteen_bit_timer < 16'h0010, CMP_ROWS[k][1], "clear");
            wr_reg(ADDR_CONTROL, 8'h00);
            repeat (2) @(posedge clk);
            #1 chk(out, 1'b0, "output off");
        end
        $display("test compare done");
        for (int k = 0; k < 5; k++)
        begin
            wr_reg(ADDR_CONTROL, 8'h00);
            wr_reg(ADDR_CONTROL, CAP_ROWS[k][13:6]);
            n0 = evts;
            repeat (16) pulse(7'h40);
            #1 chk(16'(evts - n0), CAP_ROWS[k][5:0], "capture count");
        end
        wr_reg(ADDR_CONTROL, 8'h85);
        run <= 1'b0;
        @(posedge clk);
        #1 t = tmr.sixteen_bit_timer;
        pulse(7'h40);
        rd_reg(ADDR_VAL_LO, d);
        rd_reg(ADDR_VAL_HI, h);
        chk({h, d}, t, "captured timer");
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(ADDR_CAP_SRC, 8'(k));
            n0 = evts;
            pulse(k == 7 ? 7'h7f : 7'h40 >> k);
            #1 chk(16'(evts - n0), 16'(k < 7), "source select");
        end
        $display("test capture done");
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(ADDR_CONTROL, 8'h00);
            wr_reg(ADDR_VAL_LO, PWM_ROWS[k][19:12]);
            wr_reg(ADDR_VAL_HI, PWM_ROWS[k][11:4]);
            wr_reg(ADDR_CONTROL, PWM_ROWS[k][27:20]);
            wait_hit(1'b1, got, gtr);
            wait_hit(1'b1, got, gtr);
            chk(got, 1'b1, "rollover");
            n = 0;
            repeat (16) @(posedge clk) #1 n += (out === 1'b1);
            chk(16'(n), PWM_ROWS[k][3:0], "width");
        end
        $display("test pwm done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ADDR_CONTROL, d);
        chk({d, 7'h00, out}, 16'h0000, "state after reset");
        $display("test mid-run reset done");
        close_out();
    end
endmodule
bind ccp_unit ccp_unit_chk i_ccp_unit_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_timer(i_timer), .i_src(i_src), .i_adc_sel(i_adc_sel), .o_out(o_out),
    .o_event(o_event), .o_adc_trigger(o_adc_trigger), .o_timer_clear(o_timer_clear),
    .o_period_clear(o_period_clear));
